// file: inc/rsc_pkg.sv
package rsc_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses in the special-function register space
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RSC_ADDR_CAUSE   = 8'hEF;  // Reset cause and source enables.
  localparam logic [7:0] RSC_ADDR_MONITOR = 8'hFF;  // Supply monitor control.

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int RSC_BIT_MON_EN = 7;  // Supply monitor enable.
  localparam int RSC_BIT_STAT   = 6;  // Live supply level status.
  localparam int RSC_BIT_UNUSED = 7;  // Unused top bit of the cause register.
  localparam int RSC_BIT_MEM    = 6;  // Memory error flag.
  localparam int RSC_BIT_CMP    = 5;  // Comparator enable and flag.
  localparam int RSC_BIT_SW     = 4;  // Software force and flag.
  localparam int RSC_BIT_WDT    = 3;  // Watchdog flag.
  localparam int RSC_BIT_MCD    = 2;  // Clock loss enable and flag.
  localparam int RSC_BIT_POR    = 1;  // Power-on flag and monitor select.
  localparam int RSC_BIT_PIN    = 0;  // Pin reset flag.
  localparam int RSC_NCAUSE     = 7;  // Number of cause bits.

  // ---------------------------------------------------------------------------
  // Reset values and constant read fields
  // ---------------------------------------------------------------------------
  localparam logic [6:0] RSC_CAUSE_NONE = 7'h00;  // No cause recorded.
  localparam logic [6:0] RSC_CAUSE_POR  = 7'h02;  // Power-on cause only.
  localparam logic [5:0] RSC_RSV_READ   = 6'h00;  // Reserved monitor bits read value.
  localparam logic [7:0] RSC_READ_NONE  = 8'h00;  // Read data of an unmapped address.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int RSC_CLK_PERIOD_NS   = 40;    // System clock period.
  localparam int RSC_MCD_TIMEOUT_US  = 100;   // Clock loss timeout.
  localparam int RSC_RESET_DELAY_NS  = 5000;  // Least reset hold before release.
  localparam int RSC_MCD_CYCLES      =
    (RSC_MCD_TIMEOUT_US * 1000 + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int RSC_HOLD_CYCLES     =
    (RSC_RESET_DELAY_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int RSC_WDT_DIV         = 12;    // Watchdog clock divider.

  // ---------------------------------------------------------------------------
  // Program memory limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RSC_LIMIT_LARGE = 16'h3DFF;  // Larger memory variant.
  localparam logic [15:0] RSC_LIMIT_SMALL = 16'h1FFF;  // Smaller memory variant.

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_ST_HOLD = 2'b01,  // System held in reset.
    RSC_ST_RUN  = 2'b10   // System running.
  } rsc_state_t;

endpackage : rsc_pkg

// file: src/rsc_sync3.sv
// -----------------------------------------------------------------------------
// Three-stage input synchroniser
// -----------------------------------------------------------------------------
// A change is accepted once the second and third stages agree, which also
// rejects a single-cycle glitch that slips past the first stage.
module rsc_sync3 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;  // First stage, read only by the second.
      logic s2_q;  // Second stage.
      logic s3_q;  // Third stage.
      logic out_d; // Next filtered value.

      // The output follows only when the two settled stages agree.
      always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : sync_q[i];
      end

      // Stage registers.
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          s1_q      <= RESET_VAL[i];
          s2_q      <= RESET_VAL[i];
          s3_q      <= RESET_VAL[i];
          sync_q[i] <= RESET_VAL[i];
        end else begin
          s1_q      <= async_in[i];
          s2_q      <= s1_q;
          s3_q      <= s2_q;
          sync_q[i] <= out_d;
        end
      end
    end
  endgenerate

endmodule : rsc_sync3

// file: src/rsc_timeout.sv
// -----------------------------------------------------------------------------
// Level timeout counter
// -----------------------------------------------------------------------------
// Counts cycles while the level stands and raises trip once LIMIT cycles have
// passed; the count restarts whenever the level drops.
module rsc_timeout #(
  parameter int LIMIT = 16
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic level,
  output logic      trip_q
);

  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0] cnt_q;  // Cycles the level has stood.
  logic [W-1:0] cnt_d;  // Next count.
  logic         trip_d; // Next trip value.

  // Saturating count; the ceiling keeps trip standing until the level drops.
  always_comb begin
    if (!level) begin
      cnt_d = '0;
    end else if (cnt_q == W'(LIMIT)) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
    trip_d = (cnt_d == W'(LIMIT));
  end

  // Count registers.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      trip_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      trip_q <= trip_d;
    end
  end

endmodule : rsc_timeout

// file: src/rsc_controller.sv
// Contract
// - Monitor enable bit switches the supply monitor.
// - Supply reset needs monitor enabled and selected.
// - Status bit shows live supply monitor output.
// - Reserved monitor bits ignore writes.
// - Low pin resets; pin flag set on exit.
// - Clock stalled past timeout causes reset.
// - Clock loss bit: flag reads, enable writes.
// - Non-power resets leave reset pin undriven.
// - Comparator selectable as reset source, flagged.
// - Watchdog restarted at clock/12; flag bit3.
// - Protected write beyond limit causes reset.
// - Read or fetch beyond limit causes reset.
// - Security-forbidden access causes memory reset.
// - Memory error flag set only after it.
// - Writing one forces reset; flag follows.
// - Power flag after power/monitor reset; selects monitor.
// - Read-modify-write sees stored enables, not flags.
// - Top cause bit reads zero always.
// - Other resets clear power flag.
// - Power-on disables monitor; others preserve it.
module rsc_controller
  import rsc_pkg::*;
#(
  parameter bit MEM_LARGE = 1'b1  // Larger program memory variant.
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_rmw,
  output logic      [7:0]  sfr_rdata_q,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out_q,
  output logic             rst_pin_oe_q,
  input  wire logic        supply_above_in,
  input  wire logic        comparator_out_in,
  input  wire logic        clock_stall_in,
  input  wire logic        watchdog_timeout,
  input  wire logic        program_store_write_enable,
  input  wire logic        pgm_write_req,
  input  wire logic        pgm_read_req,
  input  wire logic        fetch_req,
  input  wire logic [15:0] pgm_addr,
  input  wire logic        security_violation,
  output logic             sys_reset_q,
  output logic             supply_monitor_enable_q,
  output logic             wdt_restart_q,
  output logic             wdt_tick_q
);

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  logic [3:0] async_in;  // Pin, supply, comparator and clock stall levels.
  logic [3:0] sync_in;   // Filtered copies on the system clock.
  logic       pin_s;     // Reset pin level, low means reset.
  logic       supply_s;  // Supply above threshold.
  logic       cmp_s;     // Non-inverting input above inverting input.
  logic       stall_s;   // System clock seen stalled.

  assign async_in = {clock_stall_in, comparator_out_in, supply_above_in, rst_pin_in};
  assign pin_s    = sync_in[0];
  assign supply_s = sync_in[1];
  assign cmp_s    = sync_in[2];
  assign stall_s  = sync_in[3];

  rsc_sync3 #(
    .WIDTH     (4),
    .RESET_VAL (4'h7)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (async_in),
    .sync_q   (sync_in)
  );

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  rsc_state_t state_q;    // Sequencer state.
  rsc_state_t state_d;    // Next sequencer state.
  logic       mcd_en_q;   // Stored clock loss detector enable.
  logic       mcd_trip;   // Clock stalled past the timeout.
  logic       hold_done;  // Least hold time has passed.

  // The stall level is only timed while the detector is enabled and running.
  rsc_timeout #(
    .LIMIT (RSC_MCD_CYCLES)
  ) u_mcd (
    .clock  (clock),
    .reset  (reset),
    .level  (stall_s && mcd_en_q && (state_q == RSC_ST_RUN)),
    .trip_q (mcd_trip)
  );

  // The hold counter restarts on every entry to the hold state.
  rsc_timeout #(
    .LIMIT (RSC_HOLD_CYCLES)
  ) u_hold (
    .clock  (clock),
    .reset  (reset),
    .level  (state_q == RSC_ST_HOLD),
    .trip_q (hold_done)
  );

  // ---------------------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------------------
  logic                    sel_q;     // Supply monitor selected as source.
  logic                    cmp_en_q;  // Comparator selected as source.
  logic [15:0]             limit;     // Last legal program address.
  logic                    beyond;    // Access address past the limit.
  logic                    run;       // System running.
  logic                    wr_cause;  // Write to the cause register.
  logic                    wr_mon;    // Write to the monitor register.
  logic [RSC_NCAUSE-1:0]   src;       // Active reset sources.
  logic                    level_src; // A level source still stands.

  assign run      = (state_q == RSC_ST_RUN);
  assign wr_cause = run && sfr_wr && (sfr_addr == RSC_ADDR_CAUSE);
  assign wr_mon   = run && sfr_wr && (sfr_addr == RSC_ADDR_MONITOR);
  assign limit    = MEM_LARGE ? RSC_LIMIT_LARGE : RSC_LIMIT_SMALL;
  assign beyond   = (pgm_addr > limit);

  // Each source maps onto the cause bit it will set at release.
  always_comb begin
    src = RSC_CAUSE_NONE;
    // The pin is ignored while this block drives it, or it would latch itself.
    src[RSC_BIT_PIN] = !pin_s && !rst_pin_oe_q;
    src[RSC_BIT_POR] = supply_monitor_enable_q && sel_q && !supply_s;
    src[RSC_BIT_MCD] = mcd_trip;
    src[RSC_BIT_WDT] = run && watchdog_timeout;
    src[RSC_BIT_SW]  = wr_cause && sfr_wdata[RSC_BIT_SW];
    src[RSC_BIT_CMP] = cmp_en_q && !cmp_s;
    src[RSC_BIT_MEM] = run && ((pgm_write_req && program_store_write_enable && beyond)
                       || ((pgm_read_req || fetch_req) && beyond)
                       || security_violation);
  end

  assign level_src = src[RSC_BIT_PIN] || src[RSC_BIT_POR] || src[RSC_BIT_CMP];

  // ---------------------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------------------
  logic [RSC_NCAUSE-1:0] accum_q;   // Causes seen during this reset.
  logic [RSC_NCAUSE-1:0] accum_d;
  logic [RSC_NCAUSE-1:0] flag_q;    // Causes of the last reset.
  logic [RSC_NCAUSE-1:0] flag_d;
  logic                  sys_reset_d;
  logic                  pin_oe_d;
  logic                  restart_d;

  // Release waits for the least hold time and for level sources to clear.
  always_comb begin
    state_d     = state_q;
    accum_d     = accum_q;
    flag_d      = flag_q;
    sys_reset_d = sys_reset_q;
    pin_oe_d    = rst_pin_oe_q;
    restart_d   = 1'b0;
    case (state_q)
      RSC_ST_RUN: begin
        if (|src) begin
          state_d     = RSC_ST_HOLD;
          accum_d     = src;
          sys_reset_d = 1'b1;
          pin_oe_d    = src[RSC_BIT_POR];
        end
      end
      RSC_ST_HOLD: begin
        accum_d  = accum_q | src;
        // The pin is let go first; release then waits for its filtered level to read high.
        pin_oe_d = (rst_pin_oe_q || src[RSC_BIT_POR]) && !(hold_done && !level_src);
        if (hold_done && !level_src && !rst_pin_oe_q) begin
          state_d     = RSC_ST_RUN;
          sys_reset_d = 1'b0;
          restart_d   = 1'b1;
          // A power or monitor cause clears every other flag; any other
          // cause leaves the power flag clear.
          flag_d = accum_q[RSC_BIT_POR] ? RSC_CAUSE_POR : accum_q;
        end
      end
      default: begin
        state_d     = RSC_ST_HOLD;
        sys_reset_d = 1'b1;
      end
    endcase
  end

  // Power-on starts in hold with the power cause pending and the pin driven.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q       <= RSC_ST_HOLD;
      accum_q       <= RSC_CAUSE_POR;
      flag_q        <= RSC_CAUSE_NONE;
      sys_reset_q   <= 1'b1;
      rst_pin_oe_q  <= 1'b1;
      wdt_restart_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      accum_q       <= accum_d;
      flag_q        <= flag_d;
      sys_reset_q   <= sys_reset_d;
      rst_pin_oe_q  <= pin_oe_d;
      wdt_restart_q <= restart_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Source enables and monitor control
  // ---------------------------------------------------------------------------
  logic mon_en_d;
  logic sel_d;
  logic cmp_en_d;
  logic mcd_en_d;

  // Only the power-on reset clears these; system resets leave them alone.
  always_comb begin
    mon_en_d = supply_monitor_enable_q;
    sel_d    = sel_q;
    cmp_en_d = cmp_en_q;
    mcd_en_d = mcd_en_q;
    if (wr_mon) begin
      // Reserved and status bits are not stored.
      mon_en_d = sfr_wdata[RSC_BIT_MON_EN];
    end
    if (wr_cause) begin
      sel_d    = sfr_wdata[RSC_BIT_POR];
      cmp_en_d = sfr_wdata[RSC_BIT_CMP];
      mcd_en_d = sfr_wdata[RSC_BIT_MCD];
    end
  end

  // Enable registers, cleared by power-on only.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      supply_monitor_enable_q <= 1'b0;
      sel_q                   <= 1'b0;
      cmp_en_q                <= 1'b0;
      mcd_en_q                <= 1'b0;
    end else begin
      supply_monitor_enable_q <= mon_en_d;
      sel_q                   <= sel_d;
      cmp_en_q                <= cmp_en_d;
      mcd_en_q                <= mcd_en_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_d;

  // A read-modify-write read returns stored enables in the shared bits.
  always_comb begin
    rdata_d = sfr_rdata_q;
    if (sfr_rd) begin
      if (sfr_addr == RSC_ADDR_MONITOR) begin
        rdata_d = {supply_monitor_enable_q, supply_s, RSC_RSV_READ};
      end else if (sfr_addr == RSC_ADDR_CAUSE) begin
        rdata_d                 = {1'b0, flag_q};
        rdata_d[RSC_BIT_UNUSED] = 1'b0;
        if (sfr_rmw) begin
          rdata_d[RSC_BIT_CMP] = cmp_en_q;
          rdata_d[RSC_BIT_SW]  = 1'b0;
          rdata_d[RSC_BIT_MCD] = mcd_en_q;
          rdata_d[RSC_BIT_POR] = sel_q;
        end
      end else begin
        rdata_d = RSC_READ_NONE;
      end
    end
  end

  // Read data stands until the next read.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= RSC_READ_NONE;
    end else begin
      sfr_rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog clock divider and pin output
  // ---------------------------------------------------------------------------
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       tick_d;

  // The divider restarts with every reset so the watchdog sees a clean clock.
  always_comb begin
    tick_d = 1'b0;
    if (sys_reset_q) begin
      div_d = '0;
    end else if (div_q == 4'(RSC_WDT_DIV - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 4'h1;
    end
  end

  // Divider registers; the pin is only ever pulled low.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_q         <= '0;
      wdt_tick_q    <= 1'b0;
      rst_pin_out_q <= 1'b0;
    end else begin
      div_q         <= div_d;
      wdt_tick_q    <= tick_d;
      rst_pin_out_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_release;
    (state_q == RSC_ST_HOLD) ##1 (state_q == RSC_ST_RUN);
  endsequence

  a_mon_enable: assert property (wr_mon |=> supply_monitor_enable_q == $past(sfr_wdata[7]))
    else $error("monitor enable not taken from write");
  a_supply_gate: assert property (run && supply_monitor_enable_q && sel_q && !supply_s
                                  |=> sys_reset_q && accum_q[RSC_BIT_POR])
    else $error("supply fault ignored while selected");
  a_supply_status: assert property (sfr_rd && sfr_addr == RSC_ADDR_MONITOR
                                    |=> sfr_rdata_q[6] == $past(supply_s))
    else $error("supply status read wrong");
  a_pin_drive: assert property ($rose(rst_pin_oe_q) |-> $past(src[RSC_BIT_POR]))
    else $error("reset pin driven for non-power cause");
  a_soft_force: assert property (wr_cause && sfr_wdata[4] |=> sys_reset_q ##1 sys_reset_q)
    else $error("software force did not reset");
  a_mem_error: assert property (src[RSC_BIT_MEM] |=> sys_reset_q)
    else $error("memory error did not reset");
  a_unused_bit: assert property (sfr_rd && sfr_addr == RSC_ADDR_CAUSE |=> !sfr_rdata_q[7])
    else $error("unused cause bit read as one");
  a_mem_flag: assert property (s_release |-> flag_q[6] == ($past(accum_q[6], 1)
                                                           && !$past(accum_q[1], 1)))
    else $error("memory flag not captured at release");
  a_hold_min: assert property ($rose(sys_reset_q) |-> sys_reset_q [*8])
    else $error("reset released too early");
  a_mcd_reset: assert property (mcd_trip && run |=> sys_reset_q && accum_q[2])
    else $error("clock loss did not reset");

endmodule : rsc_controller

// file: dv/rsc_partner.sv
// -----------------------------------------------------------------------------
// Board side of the reset pin
// -----------------------------------------------------------------------------
module rsc_partner (
  input  wire logic ext_low,   // Board circuitry asks for a reset.
  input  wire logic pin_out,   // Level driven by the block.
  input  wire logic pin_oe,    // Block drives the pin.
  output logic      pin_level  // Resolved pin level.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The pull-up sets the idle level, so a released pin reads high unless the board asks for a reset.
  assign pin_level = pin_oe ? pin_out : !ext_low;
endmodule : rsc_partner

// file: dv/rsc_controller_test.sv
module rsc_controller_test
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, sfr_wr, sfr_rd, sfr_rmw, ext_low, rst_pin_in, supply_above_in;
  logic comparator_out_in, clock_stall_in, watchdog_timeout, program_store_write_enable;
  logic pgm_write_req, pgm_read_req, fetch_req, security_violation, rst_pin_out_q;
  logic rst_pin_oe_q, sys_reset_q, supply_monitor_enable_q, wdt_restart_q, wdt_tick_q;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, en;
  logic [15:0] pgm_addr;
  int          miscompares, n_tests, seed, k, i, ticks;

  rsc_controller i_dut (.clock, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rmw,
    .sfr_rdata_q, .rst_pin_in, .rst_pin_out_q, .rst_pin_oe_q, .supply_above_in,
    .comparator_out_in, .clock_stall_in, .watchdog_timeout, .program_store_write_enable,
    .pgm_write_req, .pgm_read_req, .fetch_req, .pgm_addr, .security_violation,
    .sys_reset_q, .supply_monitor_enable_q, .wdt_restart_q, .wdt_tick_q);
  rsc_partner i_pin (.ext_low, .pin_out(rst_pin_out_q), .pin_oe(rst_pin_oe_q),
    .pin_level(rst_pin_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Flag pattern that each stimulus kind should leave behind.
  function automatic logic [7:0] cause_of(input int kind);
    case (kind)
      0: return 8'h10;
      5: return 8'h08;
      6: return 8'h20;
      7: return 8'h01;
      8: return 8'h02;
      9: return 8'h04;
      default: return 8'h40;
    endcase
  endfunction : cause_of

  task automatic wrap_up;
    $display("Counts: %0d compares, %0d miscompares", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge clock) #2;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rmw  = m;
    sfr_rd   = 1'b1;
    @(posedge clock) #2;
    sfr_rd  = 1'b0;
    sfr_rmw = 1'b0;
    chk8(sfr_rdata_q, exp);
    @(posedge clock) #2;  // Idle edge, so a following read never re-raises the strobe at once.
  endtask : rd

  // Waits out the hold; notes whether the pin was driven low and the watchdog restarted.
  task automatic wait_run(input logic oe_exp);
    logic oe_seen, rs_seen;
    oe_seen = 1'b0;
    rs_seen = 1'b0;
    for (i = 0; i < 4000 && sys_reset_q !== 1'b0; i++) begin
      @(posedge clock) #2;
      oe_seen |= rst_pin_oe_q && (rst_pin_out_q === 1'b0);
      rs_seen |= wdt_restart_q;
    end
    @(posedge clock) #2;
    rs_seen |= wdt_restart_q;
    if (i >= 4000) begin
      miscompares++;
      wrap_up();
    end
    chk8(8'(oe_seen), 8'(oe_exp));
    chk8(8'(rs_seen), 8'h01);
  endtask : wait_run

  // Raises one reset source; level sources stand until the hold has begun.
  task automatic fire(input int kind);
    pgm_addr = RSC_LIMIT_LARGE + 16'h0001 + 16'($random(seed) & 32'h0FFF);
    program_store_write_enable = (kind == 1);
    // Software writes the stored enables back along with the force bit.
    if (kind == 0) wr(RSC_ADDR_CAUSE, 8'h36);
    pgm_write_req      = (kind == 1);
    pgm_read_req       = (kind == 2);
    fetch_req          = (kind == 3);
    security_violation = (kind == 4);
    watchdog_timeout   = (kind == 5);
    comparator_out_in  = (kind != 6);
    ext_low            = (kind == 7);
    supply_above_in    = (kind != 8);
    clock_stall_in     = (kind == 9);
    @(posedge clock) #2;
    {pgm_write_req, pgm_read_req, fetch_req, security_violation, watchdog_timeout} = '0;
    for (i = 0; i < 3000 && sys_reset_q !== 1'b1; i++) @(posedge clock) #2;
    if (i >= 3000) begin
      miscompares++;
      wrap_up();
    end
    {comparator_out_in, ext_low, supply_above_in, clock_stall_in} = 4'hA;
  endtask : fire

  initial begin
    seed = 46527;
    miscompares = 0;
    n_tests = 0;
    reset = 1'b1;
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_rmw, ext_low, pgm_addr} = '0;
    {clock_stall_in, watchdog_timeout, program_store_write_enable} = '0;
    {pgm_write_req, pgm_read_req, fetch_req, security_violation} = '0;
    supply_above_in   = 1'b1;
    comparator_out_in = 1'b1;
    repeat (10) @(posedge clock);
    #2 reset = 1'b0;
    wait_run(1'b1);
    rd(RSC_ADDR_CAUSE, 1'b0, 8'h02);
    rd(RSC_ADDR_MONITOR, 1'b0, 8'h40);
    ticks = 0;
    repeat (24) begin
      @(posedge clock) #2;
      ticks += int'(wdt_tick_q);
    end
    chk8(8'(ticks), 8'h02);
    wr(RSC_ADDR_MONITOR, 8'hBF);
    rd(RSC_ADDR_MONITOR, 1'b0, 8'hC0);
    // Faults that must not reset: monitor unselected, at-limit reads, unprotected write.
    supply_above_in = 1'b0;
    pgm_addr = RSC_LIMIT_LARGE;
    {pgm_read_req, fetch_req} = 2'h3;
    @(posedge clock) #2;
    pgm_addr = RSC_LIMIT_LARGE + 16'h0001;
    {pgm_read_req, fetch_req, pgm_write_req} = 3'h1;
    @(posedge clock) #2;
    pgm_write_req = 1'b0;
    repeat (6) @(posedge clock) #2;
    chk8(8'(sys_reset_q), 8'h00);
    rd(RSC_ADDR_MONITOR, 1'b0, 8'h80);
    supply_above_in = 1'b1;
    repeat (6) @(posedge clock) #2;
    en = 8'($random(seed));
    wr(RSC_ADDR_CAUSE, (en & 8'hC9) | 8'h26);
    rd(RSC_ADDR_CAUSE, 1'b1, 8'h26);
    rd(RSC_ADDR_CAUSE, 1'b0, 8'h02);
    for (k = 0; k < 10; k++) begin
      fire(k);
      wait_run(k == 8);
      rd(RSC_ADDR_CAUSE, 1'b0, cause_of(k));
      rd(RSC_ADDR_CAUSE, 1'b1, 8'h26 | (cause_of(k) & 8'h49));
      chk8(8'(supply_monitor_enable_q), 8'h01);
    end
    // A second power-on clears the monitor and every stored source enable.
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #2 reset = 1'b0;
    wait_run(1'b1);
    rd(RSC_ADDR_MONITOR, 1'b0, 8'h40);
    rd(RSC_ADDR_CAUSE, 1'b1, 8'h00);
    wrap_up();
  end
endmodule : rsc_controller_test
